// ---- design/rrd_pkg.sv ----
package rrd_pkg;

    // Reset domains of the covered register file.
    typedef struct packed {
        logic touchLive;
        logic touchCal;
        logic touchCalAdc;
        logic touchPitch;
        logic keypad;
        logic powerFirst;
        logic powerSecond;
        logic lamp;
        logic frontLight;
        logic resetCtrl;
        logic infrared;
        logic serialRom;
        logic volume;
        logic combinedStatus;
    } rrd_strobes_s;

    // Action taken by one register group.
    typedef enum logic [1:0] {
        RRD_HOLD = 2'h0,
        RRD_INIT = 2'h1,
        RRD_ZERO = 2'h3
    } rrd_action_e;

    // Detected condition, Gray coded along the usual path.
    typedef enum logic [2:0] {
        RRD_COND_NONE = 3'h0,
        RRD_COND_A = 3'h1,
        RRD_COND_B = 3'h3,
        RRD_COND_D = 3'h2,
        RRD_COND_C = 3'h6
    } rrd_cond_e;

    localparam logic [7:0] RRD_ZERO_VALUE = 8'h00;
    localparam int RRD_SYNC_STAGES = 3;
    localparam logic [2:0] RRD_SYNC_INIT = 3'h0;

endpackage

// ---- design/rrd_pin_sync.sv ----
module rrd_pin_sync
#(
    parameter logic IDLE_LEVEL = 1'h0
)
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Pin and clean level
    input wire logic pinIn,
    output logic level
);

    logic [rrd_pkg::RRD_SYNC_STAGES-1:0] stages;

    // Only the second and third stages are compared, so metastability in the first never reaches the output.
    // Stages reset to the pin's idle level, so release of reset does not look like a press.
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            stages <= {rrd_pkg::RRD_SYNC_STAGES{IDLE_LEVEL}};
        else
            stages <= {stages[1:0], pinIn};
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            level <= IDLE_LEVEL;
        else if (stages[1] == stages[2])
            level <= stages[2];
    end

endmodule

// ---- design/rrd_reset_domain_ctrl.sv ----
module rrd_reset_domain_ctrl
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Reset sources
    input wire logic powerOnDetect,
    input wire logic hardResetSwitch_n,
    input wire logic resetSwitch_n,
    // Control bits from the register file
    input wire logic softResetBit,
    input wire logic switchResetEnable,
    input wire logic sysPowerWrite,
    input wire logic sysPowerOnBit,
    // Per-register reset strobes
    output rrd_pkg::rrd_strobes_s initStrobe,
    output rrd_pkg::rrd_strobes_s zeroStrobe,
    // Last condition taken
    output rrd_pkg::rrd_cond_e lastCond
);

    logic powerOnLevel;
    logic hardLevel_n;
    logic switchLevel_n;
    logic powerOnPrev;
    logic hardPrev_n;
    logic switchPrev_n;
    logic powerOnEdge;
    logic hardEdge;
    logic switchEdge;
    logic condA;
    logic condB;
    logic condC;
    logic condD;
    rrd_pkg::rrd_cond_e next_cond;
    rrd_pkg::rrd_strobes_s next_init;
    rrd_pkg::rrd_strobes_s next_zero;

    // Pins arrive from outside the clock domain.
    rrd_pin_sync powerSync
    (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .pinIn(powerOnDetect),
        .level(powerOnLevel)
    );

    rrd_pin_sync
    #(
        .IDLE_LEVEL(1'h1)
    )
    hardSync
    (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .pinIn(hardResetSwitch_n),
        .level(hardLevel_n)
    );

    rrd_pin_sync
    #(
        .IDLE_LEVEL(1'h1)
    )
    switchSync
    (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .pinIn(resetSwitch_n),
        .level(switchLevel_n)
    );

    // Previous levels start as idle so a switch held through reset fires once after release.
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            powerOnPrev <= 1'b0;
            hardPrev_n <= 1'b1;
            switchPrev_n <= 1'b1;
        end
        else
        begin
            powerOnPrev <= powerOnLevel;
            hardPrev_n <= hardLevel_n;
            switchPrev_n <= switchLevel_n;
        end
    end

    assign powerOnEdge = powerOnLevel && !powerOnPrev;
    assign hardEdge = !hardLevel_n && hardPrev_n;
    assign switchEdge = !switchLevel_n && switchPrev_n;

    assign condA = powerOnEdge || hardEdge;
    assign condB = powerOnEdge || softResetBit || (switchEdge && switchResetEnable);
    assign condC = switchEdge && !switchResetEnable;
    assign condD = sysPowerWrite && !sysPowerOnBit;

    // Choose the most extensive condition present this cycle.
    always_comb
    begin
        if (condA)
            next_cond = rrd_pkg::RRD_COND_A;
        else if (condB)
            next_cond = rrd_pkg::RRD_COND_B;
        else if (condD)
            next_cond = rrd_pkg::RRD_COND_D;
        else if (condC)
            next_cond = rrd_pkg::RRD_COND_C;
        else
            next_cond = rrd_pkg::RRD_COND_NONE;
    end

    // B and D never coincide with A in effect, but D alone must still zero its registers even when B is absent.
    always_comb
    begin
        next_init = '0;
        next_zero = '0;
        case (next_cond)
            rrd_pkg::RRD_COND_A:
            begin
                next_init = '1;
            end
            rrd_pkg::RRD_COND_B:
            begin
                next_init = '1;
                next_init.touchCal = 1'b0;
                next_init.touchCalAdc = 1'b0;
                next_init.touchPitch = 1'b0;
            end
            rrd_pkg::RRD_COND_D:
            begin
                next_init = '1;
                next_init.touchCal = 1'b0;
                next_init.touchCalAdc = 1'b0;
                next_init.touchPitch = 1'b0;
                next_init.powerFirst = 1'b0;
                next_init.lamp = 1'b0;
                next_init.frontLight = 1'b0;
                next_zero.powerFirst = 1'b1;
                next_zero.lamp = 1'b1;
                next_zero.frontLight = 1'b1;
            end
            rrd_pkg::RRD_COND_C:
            begin
                next_init = '0;
            end
            default:
            begin
                next_init = '0;
            end
        endcase
    end

    // Strobes last as long as their condition (one cycle for a pin edge) and are registered so the register file sees clean levels.
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            initStrobe <= '0;
            zeroStrobe <= '0;
        end
        else
        begin
            initStrobe <= next_init;
            zeroStrobe <= next_zero;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            lastCond <= rrd_pkg::RRD_COND_NONE;
        else if (next_cond != rrd_pkg::RRD_COND_NONE)
            lastCond <= next_cond;
    end

endmodule

// ---- verification/rrd_reset_domain_ctrl_assertions.sv ----
module rrd_reset_domain_ctrl_assertions
(
    // Watched ports
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic hardResetSwitch_n,
    input wire logic resetSwitch_n,
    input wire logic softResetBit,
    input wire logic switchResetEnable,
    input wire logic sysPowerWrite,
    input wire logic sysPowerOnBit,
    input rrd_pkg::rrd_strobes_s initStrobe,
    input rrd_pkg::rrd_strobes_s zeroStrobe,
    input rrd_pkg::rrd_cond_e lastCond
);
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);
    soft_init_a: assert property (softResetBit |=> (initStrobe | 14'h1c00) == 14'h3fff && zeroStrobe == 0)
        else $error("soft");
    power_off_a: assert property (sysPowerWrite && !sysPowerOnBit && !softResetBit |=>
        zeroStrobe == 14'h160 && initStrobe == 14'h229f || initStrobe == 14'h3fff) else $error("off");
    zero_only_d_a: assert property (zeroStrobe != 0 |-> zeroStrobe == 14'h160 && lastCond == rrd_pkg::RRD_COND_D)
        else $error("zero");
    cal_only_a_a: assert property (initStrobe.touchCal |-> initStrobe == 14'h3fff && lastCond == rrd_pkg::RRD_COND_A)
        else $error("cal");
    hold_c_a: assert property ($changed(lastCond) && lastCond == rrd_pkg::RRD_COND_C |-> initStrobe == 0)
        else $error("hold");
    init_b_d_a: assert property (initStrobe != 0 && !initStrobe.touchCal |-> initStrobe == 14'h23ff
        || initStrobe == 14'h229f) else $error("init");
    hard_switch_a: assert property ($fell(hardResetSwitch_n) |-> ##[2:8] initStrobe == 14'h3fff)
        else $error("hard");
    switch_hold_a: assert property ($fell(resetSwitch_n) && !switchResetEnable |->
        ##[2:8] lastCond == rrd_pkg::RRD_COND_C) else $error("switch");
endmodule
bind rrd_reset_domain_ctrl rrd_reset_domain_ctrl_assertions i_chk (.core_clk, .rst_n, .hardResetSwitch_n,
    .resetSwitch_n, .softResetBit, .switchResetEnable, .sysPowerWrite, .sysPowerOnBit, .initStrobe, .zeroStrobe, .lastCond);

// ---- verification/rrd_src_model.sv ----
module rrd_src_model
(
    // Clock
    input wire logic core_clk,
    // Power-on level, hard switch and reset switch
    output logic [2:0] pins
);
    timeunit 1ns;
    timeprecision 100ps;
    initial
        pins = 3'h3;
    // Pins pass a synchronizer, so a press is held for eight clocks.
    task automatic press(input int p);
        @(posedge core_clk);
        #1;
        pins[p] = ~pins[p];
        repeat (8) @(posedge core_clk);
        #1;
        pins[p] = ~pins[p];
        repeat (8) @(posedge core_clk);
        #1;
    endtask
endmodule

// ---- verification/tb_register_reset_domain_control.sv ----
module tb_register_reset_domain_control;
    timeunit 1ns;
    timeprecision 100ps;
    logic core_clk = 1'h0, rst_n = 1'h0, softResetBit = 1'h0, switchResetEnable = 1'h0;
    logic sysPowerWrite = 1'h0, sysPowerOnBit = 1'h0;
    logic [2:0] pins;
    logic [31:0] seed = 32'h3;
    rrd_pkg::rrd_strobes_s initStrobe, zeroStrobe;
    rrd_pkg::rrd_cond_e lastCond;
    int num_errors = 0, checked = 0, cycles = 0, lastExp = 0;
    always #2.5 core_clk = ~core_clk;
    rrd_src_model i_src (.core_clk, .pins);
    rrd_reset_domain_ctrl i_dut (.core_clk, .rst_n, .powerOnDetect(pins[2]), .hardResetSwitch_n(pins[1]),
        .resetSwitch_n(pins[0]), .softResetBit, .switchResetEnable, .sysPowerWrite, .sysPowerOnBit,
        .initStrobe, .zeroStrobe, .lastCond);
    function automatic logic [31:0] xorshift(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        return s ^ (s << 5);
    endfunction
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic compare_cond(input int c);
        if (c != 0)
            lastExp = c;
        check(16'(initStrobe), c == 1 ? 16'h3fff : c == 3 ? 16'h23ff : c == 2 ? 16'h229f : 16'h0);
        check(16'(zeroStrobe), c == 2 ? 16'h160 : 16'h0);
        check(16'(lastCond), 16'(lastExp));
    endtask
    task automatic pin_event(input int p, input logic en, input int c);
        switchResetEnable = en;
        fork
            i_src.press(p);
            begin
                for (int n = 0; n < 12; n++)
                begin
                    @(posedge core_clk);
                    #1;
                    if (initStrobe != 0 || lastCond != lastExp)
                        break;
                end
                compare_cond(c);
            end
        join
    endtask
    task automatic finish_test();
        $display("%0d checks, %0d mismatches", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 1000)
        begin
            num_errors++;
            finish_test();
        end
    end
    initial
    begin
        repeat (12) @(posedge core_clk);
        #1;
        rst_n = 1'h1;
        @(posedge core_clk);
        #1;
        // Random mixes of soft reset and power writes, coinciding ones included.
        for (int i = 0; i < 24; i++)
        begin
            seed = xorshift(seed);
            softResetBit = seed[0] & seed[3];
            sysPowerWrite = seed[1];
            sysPowerOnBit = seed[2];
            @(posedge core_clk);
            #1;
            compare_cond(softResetBit ? 3 : sysPowerWrite && !sysPowerOnBit ? 2 : 0);
        end
        softResetBit = 1'h0;
        sysPowerWrite = 1'h0;
        $display("same-clock test done");
        pin_event(1, 1'h1, 1);
        pin_event(2, 1'h1, 1);
        pin_event(0, 1'h1, 3);
        pin_event(0, 1'h0, 6);
        $display("pin test done");
        finish_test();
    end
endmodule
